//--- hw/sfrb_pkg.sv
package sfrb_pkg;
   // full upper-bank addresses, bit 7 set
   localparam logic [7:0] ADDR_INDIRECT = 8'h80;
   localparam logic [7:0] ADDR_OPTION = 8'h81;
   localparam logic [7:0] ADDR_PC_LOW = 8'h82;
   localparam logic [7:0] ADDR_STATUS = 8'h83;
   localparam logic [7:0] ADDR_POINTER = 8'h84;
   localparam logic [7:0] ADDR_PORTA_DIR = 8'h85;
   localparam logic [7:0] ADDR_PORTB_DIR = 8'h86;
   localparam logic [7:0] ADDR_PORTC_DIR = 8'h87;
   localparam logic [7:0] ADDR_PC_LATCH = 8'h8A;
   localparam logic [7:0] ADDR_INT_CTRL = 8'h8B;
   localparam logic [7:0] ADDR_PERIPH_IE = 8'h8C;
   localparam logic [7:0] ADDR_RESET_CAUSE = 8'h8E;
   localparam logic [7:0] ADDR_T2_PERIOD = 8'h92;
   localparam logic [7:0] ADDR_SSP_ADDR = 8'h93;
   localparam logic [7:0] ADDR_SSP_STATE = 8'h94;
   localparam logic [7:0] ADDR_ANALOG_CFG = 8'h9F;
   localparam logic BANK1_FLAG = 1'h1;
   localparam logic [1:0] BANK1_CODE = 2'h1;
   // status bit positions
   localparam int ST_IND_BANK = 7;
   localparam int ST_BANK_HIGH = 6;
   localparam int ST_BANK_LOW = 5;
   localparam int ST_WDOG = 4;
   localparam int ST_SLEEP = 3;
   localparam int ST_ZERO = 2;
   localparam int ST_NIB = 1;
   localparam int ST_CARRY = 0;
   // reset-cause bit positions
   localparam int RC_BROWNOUT = 0;
   localparam int RC_POWERON = 1;
   // reset values
   localparam logic [7:0] RST_STATUS_POR = 8'h18;
   localparam logic [7:0] RST_OPTION = 8'hFF;
   localparam logic [7:0] RST_DIR = 8'hFF;
   localparam logic [7:0] RST_T2_PERIOD = 8'hFF;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [1:0] RST_CAUSE_POR = 2'h0;
   // implemented-bit masks and widths; MASK_INT_KEEP is the int-ctrl bits kept on an rst_req reset, reset_n clears them all
   localparam logic [7:0] MASK_PERIPH_IE = 8'h4F;
   localparam logic [7:0] MASK_INT_KEEP = 8'h01;
   localparam int PC_HIGH_W = 5;
   localparam int SSP_CTRL_W = 2;
   localparam int SSP_FLAG_W = 6;
   localparam int ANALOG_W = 3;
   localparam int CAUSE_W = 2;

   typedef enum logic [2:0] {OP_NONE, OP_ADD, OP_SUB, OP_LOGIC, OP_CLEAR} sfrb_op_e;
   typedef enum logic [1:0] {RK_BROWNOUT, RK_EXT_PIN, RK_WATCHDOG} sfrb_rst_e;
endpackage

//--- hw/sfrb_flag_if.sv
`timescale 1ns/100ps
interface sfrb_flag_if;
   import sfrb_pkg::*;
   sfrb_op_e op;
   logic [7:0] a;
   logic [7:0] b;
   logic [7:0] result;
   logic z;
   logic dc;
   logic c;
   // which of z, dc, c the instruction drives, same order
   logic [2:0] touched;
   modport calc(input op, a, b, result, output z, dc, c, touched);
   modport user(output op, a, b, result, input z, dc, c, touched);
endinterface

//--- hw/sfrb_flag_calc.sv
`timescale 1ns/100ps
module sfrb_flag_calc
   import sfrb_pkg::*;
(
   sfrb_flag_if.calc fl
);
   logic [7:0] b_eff;
   logic cin;
   logic [8:0] sum;
   logic [4:0] nib_sum;

   always_comb begin
      b_eff = fl.b;
      cin = 1'b0;
      if (fl.op == OP_SUB) begin
         b_eff = ~fl.b;
         cin = 1'b1;
      end
      sum = {1'b0, fl.a} + {1'b0, b_eff} + {8'h00, cin};
      nib_sum = {1'b0, fl.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
      fl.c = sum[8];
      fl.dc = nib_sum[4];
      case (fl.op)
         OP_ADD, OP_SUB: begin
            fl.z = (sum[7:0] == 8'h00);
            fl.touched = 3'h7;
         end
         OP_LOGIC: begin
            fl.z = (fl.result == 8'h00);
            fl.touched = 3'h4;
         end
         OP_CLEAR: begin
            fl.z = 1'b1;
            fl.touched = 3'h4;
         end
         default: begin
            fl.z = 1'b0;
            fl.touched = 3'h0;
         end
      endcase
   end
endmodule

//--- hw/sfrb_bank.sv
`timescale 1ns/100ps
module sfrb_bank
   import sfrb_pkg::*;
#(
   parameter int PORTA_W = 6
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic rst_req,
   input wire sfrb_rst_e rst_kind,
   input wire logic sleep_exec,
   input wire logic clrwdt_exec,
   input wire logic wdt_timeout,
   input wire logic [6:0] file_addr,
   input wire logic file_rd,
   input wire logic file_wr,
   input wire logic [7:0] file_wdata,
   input wire logic alu_valid,
   input wire sfrb_op_e alu_op,
   input wire logic [7:0] alu_a,
   input wire logic [7:0] alu_b,
   input wire logic [7:0] alu_result,
   input wire logic [7:0] pc_low,
   input wire logic [SSP_FLAG_W-1:0] ssp_flags,
   output logic [7:0] rd_data_ff,
   output logic rd_hit_ff,
   output logic [7:0] status_ff,
   output logic [7:0] option_ff,
   output logic [7:0] pointer_ff,
   output logic [PORTA_W-1:0] port_a_dir_ff,
   output logic [7:0] port_b_dir_ff,
   output logic [7:0] port_c_dir_ff,
   output logic [PC_HIGH_W-1:0] pc_latch_ff,
   output logic pc_load_ff,
   output logic [12:0] pc_target_ff,
   output logic [7:0] int_ctrl_ff,
   output logic [7:0] periph_ie_ff,
   output logic [CAUSE_W-1:0] reset_cause_ff,
   output logic [7:0] t2_period_ff,
   output logic [7:0] ssp_addr_ff,
   output logic [SSP_CTRL_W-1:0] ssp_ctrl_ff,
   output logic [ANALOG_W-1:0] analog_cfg_ff
);
   generate
      if (PORTA_W < 1 || PORTA_W > 8) begin : g_bad_width
         $error("PORTA_W must be 1 to 8");
      end
   endgenerate

   sfrb_flag_if fl ();

   logic is_common;
   logic in_bank1;
   logic sel;
   logic [7:0] eff_addr;
   logic [7:0] nxt_rd_data;
   logic nxt_rd_hit;
   logic [7:0] nxt_status;
   logic st_wr;

   assign fl.op = alu_valid ? alu_op : OP_NONE;
   assign fl.a = alu_a;
   assign fl.b = alu_b;
   assign fl.result = alu_result;

   sfrb_flag_calc u_calc (
      .fl(fl)
   );

   always_comb begin
      case (file_addr)
         7'h00, 7'h02, 7'h03, 7'h04, 7'h0A, 7'h0B: is_common = 1'b1;
         default: is_common = 1'b0;
      endcase
   end

   assign in_bank1 = (status_ff[ST_BANK_HIGH:ST_BANK_LOW] == BANK1_CODE);
   assign sel = is_common || in_bank1;
   assign eff_addr = {BANK1_FLAG, file_addr};
   assign st_wr = file_wr && sel && (eff_addr == ADDR_STATUS);

   function automatic logic wr_at(input logic [7:0] a);
      wr_at = file_wr && sel && (eff_addr == a);
   endfunction

   always_comb begin
      nxt_status = status_ff;
      if (st_wr) begin
         nxt_status[ST_IND_BANK:ST_BANK_LOW] = file_wdata[ST_IND_BANK:ST_BANK_LOW];
         if (!fl.touched[2]) nxt_status[ST_ZERO] = file_wdata[ST_ZERO];
         if (!fl.touched[1]) nxt_status[ST_NIB] = file_wdata[ST_NIB];
         if (!fl.touched[0]) nxt_status[ST_CARRY] = file_wdata[ST_CARRY];
      end
      if (fl.touched[2]) nxt_status[ST_ZERO] = fl.z;
      if (fl.touched[1]) nxt_status[ST_NIB] = fl.dc;
      if (fl.touched[0]) nxt_status[ST_CARRY] = fl.c;
      if (clrwdt_exec) begin
         nxt_status[ST_WDOG] = 1'b1;
         nxt_status[ST_SLEEP] = 1'b1;
      end
      if (sleep_exec) begin
         nxt_status[ST_WDOG] = 1'b1;
         nxt_status[ST_SLEEP] = 1'b0;
      end
      if (wdt_timeout) nxt_status[ST_WDOG] = 1'b0;
      if (rst_req) begin
         nxt_status[ST_IND_BANK:ST_BANK_LOW] = 3'h0;
         // a write or alu result in the reset cycle is dropped, flags stay as they were except on brown-out, which loads RST_STATUS_POR
         nxt_status[ST_ZERO:ST_CARRY] = status_ff[ST_ZERO:ST_CARRY];
         case (rst_kind)
            RK_BROWNOUT: nxt_status = RST_STATUS_POR;
            RK_WATCHDOG: nxt_status[ST_WDOG] = 1'b0;
            default: nxt_status = nxt_status;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         status_ff <= RST_STATUS_POR;
      end else begin
         status_ff <= nxt_status;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pc_latch_ff <= '0;
         pc_load_ff <= 1'b0;
         pc_target_ff <= '0;
      end else if (rst_req) begin
         pc_latch_ff <= '0;
         pc_load_ff <= 1'b0;
         pc_target_ff <= '0;
      end else begin
         pc_load_ff <= wr_at(ADDR_PC_LOW);
         if (wr_at(ADDR_PC_LOW)) pc_target_ff <= {pc_latch_ff, file_wdata};
         if (wr_at(ADDR_PC_LATCH)) pc_latch_ff <= file_wdata[PC_HIGH_W-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         port_a_dir_ff <= '1;
         port_b_dir_ff <= RST_DIR;
         port_c_dir_ff <= RST_DIR;
      end else if (rst_req) begin
         port_a_dir_ff <= '1;
         port_b_dir_ff <= RST_DIR;
         port_c_dir_ff <= RST_DIR;
      end else begin
         if (wr_at(ADDR_PORTA_DIR)) port_a_dir_ff <= file_wdata[PORTA_W-1:0];
         if (wr_at(ADDR_PORTB_DIR)) port_b_dir_ff <= file_wdata;
         if (wr_at(ADDR_PORTC_DIR)) port_c_dir_ff <= file_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         option_ff <= RST_OPTION;
         t2_period_ff <= RST_T2_PERIOD;
      end else if (rst_req) begin
         option_ff <= RST_OPTION;
         t2_period_ff <= RST_T2_PERIOD;
      end else begin
         if (wr_at(ADDR_OPTION)) option_ff <= file_wdata;
         if (wr_at(ADDR_T2_PERIOD)) t2_period_ff <= file_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         int_ctrl_ff <= RST_ZERO;
         periph_ie_ff <= RST_ZERO;
         ssp_addr_ff <= RST_ZERO;
         ssp_ctrl_ff <= '0;
         analog_cfg_ff <= '0;
      end else if (rst_req) begin
         int_ctrl_ff <= int_ctrl_ff & MASK_INT_KEEP;
         periph_ie_ff <= RST_ZERO;
         ssp_addr_ff <= RST_ZERO;
         ssp_ctrl_ff <= '0;
         analog_cfg_ff <= '0;
      end else begin
         if (wr_at(ADDR_INT_CTRL)) int_ctrl_ff <= file_wdata;
         if (wr_at(ADDR_PERIPH_IE)) periph_ie_ff <= file_wdata & MASK_PERIPH_IE;
         if (wr_at(ADDR_SSP_ADDR)) ssp_addr_ff <= file_wdata;
         if (wr_at(ADDR_SSP_STATE)) ssp_ctrl_ff <= file_wdata[7:8-SSP_CTRL_W];
         if (wr_at(ADDR_ANALOG_CFG)) analog_cfg_ff <= file_wdata[ANALOG_W-1:0];
      end
   end

   // pointer is unknown at power-up, zero chosen; kept on other resets
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pointer_ff <= RST_ZERO;
      end else if (wr_at(ADDR_POINTER) && !rst_req) begin
         pointer_ff <= file_wdata;
      end
   end

   // cause bits, hardware clear beats software set
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         reset_cause_ff <= RST_CAUSE_POR;
      end else if (rst_req && rst_kind == RK_BROWNOUT) begin
         reset_cause_ff[RC_BROWNOUT] <= 1'b0;
      end else if (wr_at(ADDR_RESET_CAUSE) && !rst_req) begin
         reset_cause_ff <= file_wdata[CAUSE_W-1:0];
      end
   end

   always_comb begin
      nxt_rd_data = 8'h00;
      nxt_rd_hit = sel;
      case (eff_addr)
         ADDR_OPTION: nxt_rd_data = option_ff;
         ADDR_PC_LOW: nxt_rd_data = pc_low;
         ADDR_STATUS: nxt_rd_data = status_ff;
         ADDR_POINTER: nxt_rd_data = pointer_ff;
         ADDR_PORTA_DIR: nxt_rd_data = 8'(port_a_dir_ff);
         ADDR_PORTB_DIR: nxt_rd_data = port_b_dir_ff;
         ADDR_PORTC_DIR: nxt_rd_data = port_c_dir_ff;
         ADDR_PC_LATCH: nxt_rd_data = 8'(pc_latch_ff);
         ADDR_INT_CTRL: nxt_rd_data = int_ctrl_ff;
         ADDR_PERIPH_IE: nxt_rd_data = periph_ie_ff;
         ADDR_RESET_CAUSE: nxt_rd_data = 8'(reset_cause_ff);
         ADDR_T2_PERIOD: nxt_rd_data = t2_period_ff;
         ADDR_SSP_ADDR: nxt_rd_data = ssp_addr_ff;
         ADDR_SSP_STATE: nxt_rd_data = {ssp_ctrl_ff, ssp_flags};
         ADDR_ANALOG_CFG: nxt_rd_data = 8'(analog_cfg_ff);
         // indirect slot is resolved by the core, not a register here
         default: nxt_rd_hit = 1'b0;
      endcase
      if (!sel) nxt_rd_data = 8'h00;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data_ff <= 8'h00;
         rd_hit_ff <= 1'b0;
      end else begin
         rd_data_ff <= file_rd ? nxt_rd_data : 8'h00;
         rd_hit_ff <= file_rd && nxt_rd_hit;
      end
   end

   logic hw_quiet;
   assign hw_quiet = !rst_req && !sleep_exec && !clrwdt_exec && !wdt_timeout;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   a_common_status: assert property (file_rd && file_addr == 7'h03 && !in_bank1
      |=> rd_hit_ff && rd_data_ff == $past(status_ff))
      else $error("status not reachable from bank 0");
   a_unimpl_zero: assert property (file_rd && (file_addr == 7'h08 || file_addr == 7'h15)
      |=> rd_data_ff == 8'h00 && !rd_hit_ff)
      else $error("unimplemented location read nonzero");
   a_pc_transfer: assert property (wr_at(ADDR_PC_LOW) && !rst_req
      |=> pc_load_ff && pc_target_ff == {$past(pc_latch_ff), $past(file_wdata)})
      else $error("pc latch not transferred");
   a_pin_reset: assert property (rst_req && rst_kind == RK_EXT_PIN && !sleep_exec
      && !clrwdt_exec && !wdt_timeout
      |=> status_ff[7:5] == 3'h0 && status_ff[4:0] == $past(status_ff[4:0]))
      else $error("pin reset disturbed kept status bits");
   a_dir_inputs: assert property (rst_req
      |=> (&port_a_dir_ff) && (&port_b_dir_ff) && (&port_c_dir_ff))
      else $error("direction not all ones after reset");
   a_brownout_status: assert property (rst_req && rst_kind == RK_BROWNOUT
      |=> status_ff == RST_STATUS_POR && !reset_cause_ff[RC_BROWNOUT])
      else $error("brown-out status value wrong");
   a_flag_override: assert property (st_wr && alu_valid && alu_op == OP_ADD && hw_quiet
      |=> status_ff[ST_ZERO] == $past(8'(alu_a + alu_b) == 8'h00)
      && status_ff[ST_NIB] == $past(({1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]}) > 5'h0F)
      && status_ff[ST_CARRY] == $past(({1'b0, alu_a} + {1'b0, alu_b}) > 9'h0FF))
      else $error("written flags not overridden");
   a_wdog_locked: assert property (st_wr && hw_quiet
      |=> status_ff[4:3] == $past(status_ff[4:3]))
      else $error("watchdog or sleep flag written");
   a_clear_status: assert property (st_wr && alu_valid && alu_op == OP_CLEAR
      && file_wdata == 8'h00 && hw_quiet
      |=> status_ff[7:5] == 3'h0 && status_ff[2] && status_ff[1:0] == $past(status_ff[1:0]))
      else $error("clear of status wrong");
   a_plain_write: assert property (st_wr && !alu_valid && hw_quiet
      |=> status_ff[2:0] == $past(file_wdata[2:0]))
      else $error("plain write lost flags");
   a_sub_borrow: assert property (alu_valid && alu_op == OP_SUB
      |-> fl.c == (alu_a >= alu_b) && fl.dc == (alu_a[3:0] >= alu_b[3:0]))
      else $error("borrow polarity wrong");
   a_ones_reset: assert property (rst_req
      |=> option_ff == RST_OPTION && t2_period_ff == RST_T2_PERIOD)
      else $error("option or period not all ones");
   a_sleep_flag: assert property (sleep_exec && !rst_req && !clrwdt_exec
      |=> !status_ff[ST_SLEEP] ##1 !status_ff[ST_SLEEP] || $past(clrwdt_exec) || $past(rst_req))
      else $error("sleep flag not cleared");
   a_add_carry: assert property (alu_valid && alu_op == OP_ADD
      |-> fl.c == (({1'b0, alu_a} + {1'b0, alu_b}) > 9'h0FF))
      else $error("add carry wrong");
   a_reserved_bits: assert property (file_rd && sel && eff_addr == ADDR_PERIPH_IE
      |=> (rd_data_ff & ~MASK_PERIPH_IE) == 8'h00)
      else $error("reserved bits read nonzero");
   a_cause_upper: assert property (file_rd && eff_addr == ADDR_RESET_CAUSE && sel
      |=> rd_data_ff[7:CAUSE_W] == '0)
      else $error("reset-cause upper bits nonzero");

   c_status_clear: cover property (st_wr && alu_valid && alu_op == OP_CLEAR);
   c_pc_jump: cover property (wr_at(ADDR_PC_LATCH) ##[1:4] wr_at(ADDR_PC_LOW));
   c_bank1_read: cover property (file_rd && in_bank1 && !is_common ##1 rd_hit_ff);
   c_sleep_wake: cover property (sleep_exec ##[1:20] wdt_timeout);
endmodule

//--- tb/sfrb_core_model.sv
`timescale 1ns/100ps
module sfrb_core_model
   import sfrb_pkg::*;
(
   input wire logic ref_clk,
   output logic [6:0] file_addr,
   output logic file_rd,
   output logic file_wr,
   output logic [7:0] file_wdata,
   output logic alu_valid,
   output sfrb_op_e alu_op,
   output logic [7:0] alu_a,
   output logic [7:0] alu_b,
   output logic [7:0] alu_result,
   output logic [7:0] pc_low,
   input wire logic [7:0] rd_data_ff,
   input wire logic rd_hit_ff
);
   initial begin
      file_addr = 7'h7F;
      file_wdata = 8'hA5;
      alu_a = 8'h5A;
      alu_b = 8'hC3;
      alu_result = 8'h3C;
      pc_low = 8'h5A;
      idle();
   end

   // released lines show inverted values so a stale sample never passes for data
   task automatic idle();
      file_rd = 1'b0;
      file_wr = 1'b0;
      alu_valid = 1'b0;
      alu_op = OP_NONE;
      file_addr = ~file_addr;
      file_wdata = ~file_wdata;
      alu_a = ~alu_a;
      alu_b = ~alu_b;
      alu_result = ~alu_result;
   endtask

   function automatic logic [7:0] keep_rsvd(input logic [6:0] a, input logic [7:0] d);
      return (a == ADDR_STATUS[6:0]) ? (d & 8'h3F) : d;
   endfunction

   task automatic wr(input logic [6:0] addr, input logic [7:0] data);
      @(negedge ref_clk);
      file_addr = addr;
      file_wdata = keep_rsvd(addr, data);
      file_wr = 1'b1;
      @(negedge ref_clk);
      idle();
   endtask

   task automatic rd(input logic [6:0] addr, output logic [7:0] data, output logic hit);
      @(negedge ref_clk);
      file_addr = addr;
      file_rd = 1'b1;
      @(negedge ref_clk);
      data = rd_data_ff;
      hit = rd_hit_ff;
      idle();
   endtask

   // flag-setting instruction whose destination is the status register
   task automatic alu_wr(input sfrb_op_e op, input logic [7:0] a, b, r, wd);
      @(negedge ref_clk);
      alu_op = op;
      alu_a = a;
      alu_b = b;
      alu_result = r;
      alu_valid = 1'b1;
      file_addr = ADDR_STATUS[6:0];
      file_wdata = keep_rsvd(ADDR_STATUS[6:0], wd);
      file_wr = 1'b1;
      @(negedge ref_clk);
      idle();
   endtask
endmodule

//--- tb/sfrb_bank_test.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
   comparisons++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("[FAIL] %s exp %h got %h", nm, e, g); \
   end \
end
module sfrb_bank_test
   import sfrb_pkg::*;
;
   localparam logic [3:0] S_RST = 4'h8;
   localparam logic [3:0] S_SLEEP = 4'h4;
   localparam logic [3:0] S_CLRWDT = 4'h2;
   localparam logic [3:0] S_WDT = 4'h1;
   int n_errors;
   int comparisons;
   logic ref_clk, reset_n;
   logic [3:0] ctl;
   sfrb_rst_e rst_kind;
   logic [SSP_FLAG_W-1:0] ssp_flags;
   logic [6:0] file_addr;
   logic file_rd, file_wr, alu_valid, rd_hit_ff, pc_load_ff;
   sfrb_op_e alu_op;
   logic [7:0] file_wdata, alu_a, alu_b, alu_result, pc_low, rd_data_ff, status_ff;
   logic [7:0] option_ff, pointer_ff, port_b_dir_ff, port_c_dir_ff, int_ctrl_ff;
   logic [7:0] periph_ie_ff, t2_period_ff, ssp_addr_ff;
   logic [5:0] port_a_dir_ff;
   logic [PC_HIGH_W-1:0] pc_latch_ff;
   logic [12:0] pc_target_ff;
   logic [CAUSE_W-1:0] reset_cause_ff;
   logic [SSP_CTRL_W-1:0] ssp_ctrl_ff;
   logic [ANALOG_W-1:0] analog_cfg_ff;

   sfrb_core_model core_u (.ref_clk(ref_clk), .file_addr(file_addr), .file_rd(file_rd),
      .file_wr(file_wr), .file_wdata(file_wdata), .alu_valid(alu_valid), .alu_op(alu_op),
      .alu_a(alu_a), .alu_b(alu_b), .alu_result(alu_result), .pc_low(pc_low),
      .rd_data_ff(rd_data_ff), .rd_hit_ff(rd_hit_ff));

   sfrb_bank #(.PORTA_W(6)) dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
      .rst_req(ctl[3]), .rst_kind(rst_kind), .sleep_exec(ctl[2]), .clrwdt_exec(ctl[1]),
      .wdt_timeout(ctl[0]), .file_addr(file_addr), .file_rd(file_rd), .file_wr(file_wr),
      .file_wdata(file_wdata), .alu_valid(alu_valid), .alu_op(alu_op), .alu_a(alu_a),
      .alu_b(alu_b), .alu_result(alu_result), .pc_low(pc_low), .ssp_flags(ssp_flags),
      .rd_data_ff(rd_data_ff), .rd_hit_ff(rd_hit_ff), .status_ff(status_ff),
      .option_ff(option_ff), .pointer_ff(pointer_ff), .port_a_dir_ff(port_a_dir_ff),
      .port_b_dir_ff(port_b_dir_ff), .port_c_dir_ff(port_c_dir_ff),
      .pc_latch_ff(pc_latch_ff), .pc_load_ff(pc_load_ff), .pc_target_ff(pc_target_ff),
      .int_ctrl_ff(int_ctrl_ff), .periph_ie_ff(periph_ie_ff),
      .reset_cause_ff(reset_cause_ff), .t2_period_ff(t2_period_ff),
      .ssp_addr_ff(ssp_addr_ff), .ssp_ctrl_ff(ssp_ctrl_ff), .analog_cfg_ff(analog_cfg_ff));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic stop_test();
      if (n_errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic strobe(input logic [3:0] v);
      @(negedge ref_clk);
      ctl = v;
      @(negedge ref_clk);
      ctl = 4'h0;
   endtask

   task automatic rd_chk(input logic [6:0] a, input logic h, input logic [7:0] d);
      logic [7:0] got;
      logic hit;
      core_u.rd(a, got, hit);
      `CHK("read hit", h, hit)
      `CHK("read data", d, got)
   endtask

   task automatic fl(input sfrb_op_e op, input logic [7:0] a, b, r, wd, exp);
      core_u.alu_wr(op, a, b, r, wd);
      `CHK("status after alu", exp, status_ff)
   endtask

   task automatic t_reset_values();
      `CHK("status", 8'h18, status_ff)
      `CHK("option", 8'hFF, option_ff)
      `CHK("period", 8'hFF, t2_period_ff)
      `CHK("dir a", 6'h3F, port_a_dir_ff)
      `CHK("dir b", 8'hFF, port_b_dir_ff)
      `CHK("dir c", 8'hFF, port_c_dir_ff)
      `CHK("cause", 2'h0, reset_cause_ff)
      `CHK("int ctrl", 8'h00, int_ctrl_ff)
   endtask

   task automatic t_decode();
      rd_chk(7'h05, 1'b0, 8'h00);
      rd_chk(7'h03, 1'b1, 8'h18);
      core_u.wr(7'h03, 8'hE0);
      `CHK("status moved", 8'h38, status_ff)
      rd_chk(7'h05, 1'b1, 8'h3F);
      rd_chk(7'h02, 1'b1, 8'h5A);
      rd_chk(7'h08, 1'b0, 8'h00);
      rd_chk(7'h15, 1'b0, 8'h00);
      rd_chk(7'h00, 1'b0, 8'h00);
      rd_chk(7'h14, 1'b1, 8'h2A);
      core_u.wr(7'h14, 8'hFF);
      rd_chk(7'h14, 1'b1, 8'hEA);
      `CHK("ssp ctrl", 2'h3, ssp_ctrl_ff)
      core_u.wr(7'h13, 8'hA5);
      `CHK("ssp addr", 8'hA5, ssp_addr_ff)
      core_u.wr(7'h0C, 8'hFF);
      rd_chk(7'h0C, 1'b1, 8'h4F);
      core_u.wr(7'h1F, 8'hFF);
      rd_chk(7'h1F, 1'b1, 8'h07);
      core_u.wr(7'h0E, 8'hFF);
      rd_chk(7'h0E, 1'b1, 8'h03);
   endtask

   task automatic t_pc();
      core_u.wr(7'h0A, 8'hF2);
      `CHK("pc latch", 5'h12, pc_latch_ff)
      core_u.wr(7'h02, 8'h34);
      `CHK("pc load", 1'b1, pc_load_ff)
      `CHK("pc target", 13'h1234, pc_target_ff)
      @(negedge ref_clk);
      `CHK("pc load end", 1'b0, pc_load_ff)
      rd_chk(7'h0A, 1'b1, 8'h12);
   endtask

   task automatic t_flags();
      fl(OP_ADD, 8'h08, 8'h08, 8'h10, 8'h25, 8'h3A);
      fl(OP_ADD, 8'h80, 8'h80, 8'h00, 8'h20, 8'h3D);
      fl(OP_SUB, 8'h10, 8'h01, 8'h0F, 8'h20, 8'h39);
      fl(OP_SUB, 8'h01, 8'h02, 8'hFF, 8'h27, 8'h38);
      fl(OP_CLEAR, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1C);
      fl(OP_LOGIC, 8'h00, 8'h00, 8'h00, 8'h23, 8'h3F);
   endtask

   task automatic t_sleep();
      strobe(S_SLEEP);
      `CHK("after sleep", 8'h37, status_ff)
      strobe(S_WDT);
      `CHK("after timeout", 8'h27, status_ff)
      core_u.wr(7'h03, 8'h38);
      `CHK("flags unwritable", 8'h20, status_ff)
      strobe(S_CLRWDT);
      `CHK("after clear", 8'h38, status_ff)
   endtask

   task automatic t_soft_reset();
      logic [6:0] regs [5] = '{7'h01, 7'h05, 7'h06, 7'h07, 7'h12};
      core_u.wr(7'h03, 8'h23);
      for (int i = 0; i < 5; i++) begin
         core_u.wr(regs[i], 8'h00);
      end
      core_u.wr(7'h04, 8'h55);
      core_u.wr(7'h0A, 8'h1F);
      core_u.wr(7'h0B, 8'h81);
      `CHK("option written", 8'h00, option_ff)
      rst_kind = RK_EXT_PIN;
      // a status write landing in the reset cycle must not reach the flags
      fork
         strobe(S_RST);
         core_u.wr(7'h03, 8'h27);
      join
      `CHK("status pin", 8'h1B, status_ff)
      `CHK("option pin", 8'hFF, option_ff)
      `CHK("period pin", 8'hFF, t2_period_ff)
      `CHK("dir a pin", 6'h3F, port_a_dir_ff)
      `CHK("dir b pin", 8'hFF, port_b_dir_ff)
      `CHK("dir c pin", 8'hFF, port_c_dir_ff)
      `CHK("pointer pin", 8'h55, pointer_ff)
      `CHK("latch pin", 5'h00, pc_latch_ff)
      `CHK("cause pin", 2'h3, reset_cause_ff)
      `CHK("int ctrl pin", 8'h01, int_ctrl_ff)
      `CHK("ssp addr pin", 8'h00, ssp_addr_ff)
      `CHK("ssp ctrl pin", 2'h0, ssp_ctrl_ff)
      `CHK("analog pin", 3'h0, analog_cfg_ff)
      core_u.wr(7'h03, 8'h20);
      core_u.wr(7'h06, 8'h00);
      rst_kind = RK_WATCHDOG;
      strobe(S_RST);
      `CHK("status wdog", 8'h08, status_ff)
      `CHK("dir b wdog", 8'hFF, port_b_dir_ff)
      rst_kind = RK_BROWNOUT;
      strobe(S_RST);
      `CHK("status brownout", 8'h18, status_ff)
      `CHK("cause brownout", 2'h2, reset_cause_ff)
   endtask

   initial begin
      n_errors = 0;
      comparisons = 0;
      reset_n = 1'b0;
      ctl = 4'h0;
      rst_kind = RK_EXT_PIN;
      ssp_flags = 6'h2A;
      repeat (3) @(negedge ref_clk);
      reset_n = 1'b1;
      t_reset_values();
      t_decode();
      t_pc();
      t_flags();
      t_sleep();
      t_soft_reset();
      stop_test();
   end

   // a hang past the cycle budget ends the run as a mismatch
   initial begin
      #50000;
      n_errors++;
      stop_test();
   end
endmodule
